// ### logic/tx_pin_pkg.sv
// constants for the transmitter pin control block
package tx_pin_pkg;

	localparam int NCH    = 2;
	localparam int ADR_W  = 8;
	localparam int DAT_W  = 32;
	localparam int LANE_W = 8;
	localparam int LANES  = 4;

	// register byte offsets
	localparam logic [7:0] OFS_CLK_SEL  = 8'h00;
	localparam logic [7:0] OFS_CLK_CTRL = 8'h04;
	localparam logic [7:0] OFS_MODE     = 8'h08;
	localparam logic [7:0] OFS_LINE     = 8'h0C;
	localparam logic [7:0] OFS_STATUS   = 8'h10;

	// per-transmitter field widths (transmitter b sits one width above a)
	localparam int SEL_W  = 4;
	localparam int CTRL_W = 8;
	localparam int MODE_W = 2;
	localparam int LINE_W = 2;

	// bits inside one clock-control byte
	localparam int CB_CLK_OE = 0;
	localparam int CB_INV    = 1;
	localparam int CB_MP_OE  = 2;
	localparam int CB_MP_SRC = 3;
	localparam int CB_SYNC   = 4;
	localparam int CB_OVH    = 6;

	// bits inside one line-control pair
	localparam int LB_EN = 0;
	localparam int LB_PD = 1;

	// packed configuration word that crosses into the link domain
	localparam int CFG_W        = 32;
	localparam int CFG_SEL_POS  = 0;
	localparam int CFG_CTRL_POS = 8;
	localparam int CFG_MODE_POS = 24;
	localparam int CFG_LINE_POS = 28;

	// reset values
	localparam logic [7:0]  CLK_SEL_RST  = 8'h00;
	localparam logic [15:0] CLK_CTRL_RST = 16'h0000;
	localparam logic [3:0]  MODE_RST     = 4'h0;
	localparam logic [3:0]  LINE_RST     = 4'h0;

	// clock source codes
	localparam logic [3:0] CLK_SRC_PIN  = 4'h0;
	localparam logic [3:0] CLK_SRC_ONE  = 4'h1;
	localparam logic [3:0] CLK_SRC_MAX  = 4'h7;
	localparam logic [3:0] CLK_SRC_NINE = 4'h9;
	localparam int         OC_W         = 9;
	localparam int         OC_NINE_IDX  = 8;

	typedef enum logic [1:0] {
		MODE_DS1  = 2'h0,
		MODE_E1   = 2'h1,
		MODE_2048 = 2'h2,
		MODE_6312 = 2'h3
	} tx_line_mode_e;

	typedef enum logic [1:0] {
		SYNC_NONE  = 2'h0,
		SYNC_FRAME = 2'h1,
		SYNC_MULTI = 2'h3
	} tx_sync_mode_e;

	// framing
	localparam logic [8:0] DS1_LAST_BIT = 9'h0C0;
	localparam logic [8:0] E1_LAST_BIT  = 9'h0FF;
	localparam logic [4:0] DS1_LAST_FRM = 5'h17;
	localparam logic [4:0] E1_LAST_FRM  = 5'h0F;
	localparam logic [8:0] E1_OVH_BITS  = 9'h008;
	localparam logic [7:0] E1_ALIGN     = 8'h1B;
	localparam logic [2:0] ALIGN_MSB    = 3'h7;

endpackage

// ### logic/sync_bits.sv
// two flip-flop synchroniser for a group of independent levels
`timescale 1ns/1ps
module sync_bits #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_q;

	always_ff @(posedge clk)
	begin
		meta_q <= d;
		q      <= meta_q;
	end

endmodule // sync_bits

// ### logic/bits_transmitter_pin_control.sv
// pin control for two timing-link transmitters with a wishbone register slave
//
// How it works
// - transmit clock pin follows the clock mux, its driver gated by clock-out enable
// - serial data sampled on rising or falling transmit clock edge per invert bit
// - multipurpose output driver has its own enable, independent of clock enable
// - multipurpose output carries frame sync or multiframe sync per source bit
// - source codes one to seven and nine pick output clocks one-seven and nine
// - source code zero takes the transmit clock from the multipurpose input pin
// - in DS1/E1 the multipurpose input may resync frame or multiframe on the chosen edge
// - line modes 0x use serial data input as the NRZ line stream
// - payload and optional overhead from serial input, remaining frame bits made here
// - other line modes ignore serial data input; far end holds it steady
// - line outputs high impedance when hiz pin high or line enable clear
// - line outputs also high impedance while power-down bit set
//
// Chosen here: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
module bits_transmitter_pin_control (
	input  wire logic                           clk,
	input  wire logic                           rst_b,
	input  wire logic                           linkClk,
	input  wire logic                           cyc_i,
	input  wire logic                           stb_i,
	input  wire logic                           we_i,
	input  wire logic [tx_pin_pkg::ADR_W-1:0]   adr_i,
	input  wire logic [tx_pin_pkg::LANES-1:0]   sel_i,
	input  wire logic [tx_pin_pkg::DAT_W-1:0]   dat_i,
	output logic      [tx_pin_pkg::DAT_W-1:0]   dat_o,
	output logic                                ack_o,
	input  wire logic [tx_pin_pkg::OC_W-1:0]    outputClock,
	input  wire logic                           txMultipurposeInA,
	input  wire logic                           txMultipurposeInB,
	input  wire logic                           txSerialDataInA,
	input  wire logic                           txSerialDataInB,
	input  wire logic                           lineHizInA,
	input  wire logic                           lineHizInB,
	output logic                                txClockOutA,
	output logic                                txClockOutOeA,
	output logic                                txClockOutB,
	output logic                                txClockOutOeB,
	output logic                                txMultipurposeOutA,
	output logic                                txMultipurposeOutOeA,
	output logic                                txMultipurposeOutB,
	output logic                                txMultipurposeOutOeB,
	output logic                                lineOutPosA,
	output logic                                lineOutPosOeA,
	output logic                                lineOutNegA,
	output logic                                lineOutNegOeA,
	output logic                                lineOutPosB,
	output logic                                lineOutPosOeB,
	output logic                                lineOutNegB,
	output logic                                lineOutNegOeB
);

	localparam int NCH = tx_pin_pkg::NCH;

	// bus-side registers
	logic [7:0]                    clkSel_q;
	logic [15:0]                   clkCtrl_q;
	logic [3:0]                    lineMode_q;
	logic [3:0]                    lineCtrl_q;
	logic                          reqTgl_q;
	logic                          ackTgl;
	logic [2*NCH-1:0]              status;
	logic [tx_pin_pkg::DAT_W-1:0]  rdWord;
	logic [tx_pin_pkg::DAT_W-1:0]  newWord;
	logic                          access;
	logic                          isCfg;
	logic                          busy;
	logic                          wrGo;
	logic                          ackGo;

	// link-side state
	logic                          linkRst_b;
	logic                          reqSync;
	logic                          reqSeen_q;
	logic [tx_pin_pkg::CFG_W-1:0]  cfgLink_q;
	logic [tx_pin_pkg::OC_W-1:0]   ocS;
	logic [NCH-1:0]                tinS;
	logic [NCH-1:0]                serS;
	logic [NCH-1:0]                hizS;
	logic [NCH-1:0]                drivingV;
	logic [NCH-1:0]                frameTglV;
	logic [NCH-1:0]                clkOutV;
	logic [NCH-1:0]                clkOeV;
	logic [NCH-1:0]                mpOutV;
	logic [NCH-1:0]                mpOeV;
	logic [NCH-1:0]                posV;
	logic [NCH-1:0]                negV;
	logic [NCH-1:0]                lineOeV;

	assign access = cyc_i & stb_i & ~ack_o;
	assign busy   = reqTgl_q ^ ackTgl;

	always_comb
	begin
		rdWord = '0;
		isCfg  = 1'b1;
		case (adr_i)
			tx_pin_pkg::OFS_CLK_SEL:  rdWord[7:0]  = clkSel_q;
			tx_pin_pkg::OFS_CLK_CTRL: rdWord[15:0] = clkCtrl_q;
			tx_pin_pkg::OFS_MODE:     rdWord[3:0]  = lineMode_q;
			tx_pin_pkg::OFS_LINE:     rdWord[3:0]  = lineCtrl_q;
			tx_pin_pkg::OFS_STATUS:
			begin
				rdWord[2*NCH-1:0] = status;
				isCfg             = 1'b0;
			end
			default:                  isCfg = 1'b0;
		endcase
	end

	// byte-lane merge of write data into the addressed register
	always_comb
	begin
		newWord = rdWord;
		for (int l = 0; l < tx_pin_pkg::LANES; l++)
		begin
			if (sel_i[l])
				newWord[l*tx_pin_pkg::LANE_W +: tx_pin_pkg::LANE_W] =
					dat_i[l*tx_pin_pkg::LANE_W +: tx_pin_pkg::LANE_W];
		end
	end

	// a config write waits until the previous one reached the link side
	assign wrGo  = access & we_i & isCfg & ~busy;
	assign ackGo = access & (~we_i | ~isCfg | ~busy);

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			ack_o <= 1'b0;
			dat_o <= '0;
		end
		else
		begin
			ack_o <= ackGo;
			if (ackGo && !we_i)
				dat_o <= rdWord;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			clkSel_q   <= tx_pin_pkg::CLK_SEL_RST;
			clkCtrl_q  <= tx_pin_pkg::CLK_CTRL_RST;
			lineMode_q <= tx_pin_pkg::MODE_RST;
			lineCtrl_q <= tx_pin_pkg::LINE_RST;
			reqTgl_q   <= 1'b0;
		end
		else if (wrGo)
		begin
			reqTgl_q <= ~reqTgl_q;
			case (adr_i)
				tx_pin_pkg::OFS_CLK_SEL:  clkSel_q   <= newWord[7:0];
				tx_pin_pkg::OFS_CLK_CTRL: clkCtrl_q  <= newWord[15:0];
				tx_pin_pkg::OFS_MODE:     lineMode_q <= newWord[3:0];
				tx_pin_pkg::OFS_LINE:     lineCtrl_q <= newWord[3:0];
				default:                  clkSel_q   <= clkSel_q;
			endcase
		end
	end

	sync_bits #(.W(1)) ackSyncI (
		.clk (clk),
		.d   (reqSeen_q),
		.q   (ackTgl)
	);

	sync_bits #(.W(2*NCH)) statusSyncI (
		.clk (clk),
		.d   ({frameTglV, drivingV}),
		.q   (status)
	);

	// link domain
	sync_bits #(.W(1)) rstSyncI (
		.clk (linkClk),
		.d   (rst_b),
		.q   (linkRst_b)
	);

	sync_bits #(.W(1)) reqSyncI (
		.clk (linkClk),
		.d   (reqTgl_q),
		.q   (reqSync)
	);

	sync_bits #(.W(tx_pin_pkg::OC_W)) ocSyncI (
		.clk (linkClk),
		.d   (outputClock),
		.q   (ocS)
	);

	sync_bits #(.W(3*NCH)) pinSyncI (
		.clk (linkClk),
		.d   ({lineHizInB, lineHizInA, txSerialDataInB, txSerialDataInA,
			txMultipurposeInB, txMultipurposeInA}),
		.q   ({hizS, serS, tinS})
	);

	// config words were stable since the toggle, so capture is safe
	always_ff @(posedge linkClk)
	begin
		if (!linkRst_b)
		begin
			reqSeen_q <= 1'b0;
			cfgLink_q <= {tx_pin_pkg::LINE_RST, tx_pin_pkg::MODE_RST,
				tx_pin_pkg::CLK_CTRL_RST, tx_pin_pkg::CLK_SEL_RST};
		end
		else if (reqSync != reqSeen_q)
		begin
			reqSeen_q <= reqSync;
			cfgLink_q <= {lineCtrl_q, lineMode_q, clkCtrl_q, clkSel_q};
		end
	end

	for (genvar ch = 0; ch < NCH; ch++)
	begin : g_tx
		logic [3:0]                src;
		logic [7:0]                ctrl;
		tx_pin_pkg::tx_line_mode_e mode;
		tx_pin_pkg::tx_sync_mode_e syncMode;
		logic [1:0]                line;
		logic                      clkPick;
		logic                      clkLvl_q;
		logic                      clkPrev_q;
		logic                      activeEdge;
		logic                      dataMode;
		logic                      syncHit;
		logic                      driving;
		logic [8:0]                bitCnt_q;
		logic [4:0]                frameCnt_q;
		logic [8:0]                posBit;
		logic [4:0]                posFrame;
		logic [8:0]                lastBit;
		logic [4:0]                lastFrame;
		logic                      overhead;
		logic                      inner;
		logic                      dataBit;
		logic                      frameSync_q;
		logic                      mfSync_q;
		logic                      pol_q;
		logic                      pos_q;
		logic                      neg_q;
		logic                      clkOe_q;
		logic                      mpOut_q;
		logic                      mpOe_q;
		logic                      lineOe_q;
		logic                      frameTgl_q;

		assign src  = cfgLink_q[tx_pin_pkg::CFG_SEL_POS + tx_pin_pkg::SEL_W*ch +:
			tx_pin_pkg::SEL_W];
		assign ctrl = cfgLink_q[tx_pin_pkg::CFG_CTRL_POS + tx_pin_pkg::CTRL_W*ch +:
			tx_pin_pkg::CTRL_W];
		assign mode = tx_pin_pkg::tx_line_mode_e'(cfgLink_q[tx_pin_pkg::CFG_MODE_POS +
			tx_pin_pkg::MODE_W*ch +: tx_pin_pkg::MODE_W]);
		assign line = cfgLink_q[tx_pin_pkg::CFG_LINE_POS + tx_pin_pkg::LINE_W*ch +:
			tx_pin_pkg::LINE_W];
		assign syncMode = tx_pin_pkg::tx_sync_mode_e'(ctrl[tx_pin_pkg::CB_SYNC +: 2]);

		// transmit clock mux; unused codes hold the clock low
		always_comb
		begin
			clkPick = 1'b0;
			if (src == tx_pin_pkg::CLK_SRC_PIN)
				clkPick = tinS[ch];
			else if (src <= tx_pin_pkg::CLK_SRC_MAX)
				clkPick = ocS[src - tx_pin_pkg::CLK_SRC_ONE];
			else if (src == tx_pin_pkg::CLK_SRC_NINE)
				clkPick = ocS[tx_pin_pkg::OC_NINE_IDX];
		end

		assign activeEdge = ctrl[tx_pin_pkg::CB_INV] ? (~clkLvl_q & clkPrev_q)
			: (clkLvl_q & ~clkPrev_q);
		assign dataMode = (mode == tx_pin_pkg::MODE_DS1) || (mode == tx_pin_pkg::MODE_E1);

		// input cannot carry sync while it is the clock
		assign syncHit = dataMode && syncMode != tx_pin_pkg::SYNC_NONE &&
			src != tx_pin_pkg::CLK_SRC_PIN && tinS[ch];

		assign lastBit   = (mode == tx_pin_pkg::MODE_E1) ? tx_pin_pkg::E1_LAST_BIT
			: tx_pin_pkg::DS1_LAST_BIT;
		assign lastFrame = (mode == tx_pin_pkg::MODE_E1) ? tx_pin_pkg::E1_LAST_FRM
			: tx_pin_pkg::DS1_LAST_FRM;

		always_comb
		begin
			if (syncHit || bitCnt_q >= lastBit)
				posBit = '0;
			else
				posBit = bitCnt_q + 9'h001;
			if (syncHit && syncMode == tx_pin_pkg::SYNC_MULTI)
				posFrame = '0;
			else if (posBit != '0)
				posFrame = frameCnt_q;
			else if (frameCnt_q >= lastFrame)
				posFrame = '0;
			else
				posFrame = frameCnt_q + 5'h01;
		end

		// overhead positions and internally made frame bits
		always_comb
		begin
			if (mode == tx_pin_pkg::MODE_E1)
			begin
				overhead = posBit < tx_pin_pkg::E1_OVH_BITS;
				inner    = posFrame[0] ? 1'b1
					: tx_pin_pkg::E1_ALIGN[tx_pin_pkg::ALIGN_MSB - posBit[2:0]];
			end
			else
			begin
				overhead = posBit == '0;
				inner    = posFrame[0];
			end
			if (!dataMode)
				dataBit = 1'b1;
			else if (overhead && !ctrl[tx_pin_pkg::CB_OVH])
				dataBit = inner;
			else
				dataBit = serS[ch];
		end

		assign driving = ~hizS[ch] & line[tx_pin_pkg::LB_EN] & ~line[tx_pin_pkg::LB_PD];

		always_ff @(posedge linkClk)
		begin
			if (!linkRst_b)
			begin
				clkLvl_q  <= 1'b0;
				clkPrev_q <= 1'b0;
			end
			else
			begin
				clkLvl_q  <= clkPick;
				clkPrev_q <= clkLvl_q;
			end
		end

		// framing and line coding, advanced on the active clock edge
		always_ff @(posedge linkClk)
		begin
			if (!linkRst_b)
			begin
				bitCnt_q    <= '0;
				frameCnt_q  <= '0;
				frameSync_q <= 1'b0;
				mfSync_q    <= 1'b0;
				pol_q       <= 1'b0;
				pos_q       <= 1'b0;
				neg_q       <= 1'b0;
				frameTgl_q  <= 1'b0;
			end
			else if (activeEdge)
			begin
				bitCnt_q    <= posBit;
				frameCnt_q  <= posFrame;
				frameSync_q <= dataMode && posBit == '0;
				mfSync_q    <= dataMode && posBit == '0 && posFrame == '0;
				if (dataMode && posBit == '0)
					frameTgl_q <= ~frameTgl_q;
				if (!driving)
				begin
					pos_q <= 1'b0;
					neg_q <= 1'b0;
				end
				else
				begin
					pos_q <= dataBit & ~pol_q;
					neg_q <= dataBit & pol_q;
					if (dataBit)
						pol_q <= ~pol_q;
				end
			end
			else if (!driving)
			begin
				pos_q <= 1'b0;
				neg_q <= 1'b0;
			end
		end

		// pin drivers
		always_ff @(posedge linkClk)
		begin
			if (!linkRst_b)
			begin
				clkOe_q  <= 1'b0;
				mpOut_q  <= 1'b0;
				mpOe_q   <= 1'b0;
				lineOe_q <= 1'b0;
			end
			else
			begin
				clkOe_q  <= ctrl[tx_pin_pkg::CB_CLK_OE];
				mpOe_q   <= ctrl[tx_pin_pkg::CB_MP_OE];
				mpOut_q  <= ctrl[tx_pin_pkg::CB_MP_SRC] ? mfSync_q : frameSync_q;
				lineOe_q <= driving;
			end
		end

		// each transmitter keeps its own framing, line and driver state; cfgLink_q is shared
		assign clkOutV[ch]   = clkLvl_q;
		assign clkOeV[ch]    = clkOe_q;
		assign mpOutV[ch]    = mpOut_q;
		assign mpOeV[ch]     = mpOe_q;
		assign posV[ch]      = pos_q;
		assign negV[ch]      = neg_q;
		assign lineOeV[ch]   = lineOe_q;
		assign drivingV[ch]  = lineOe_q;
		assign frameTglV[ch] = frameTgl_q;
	end

	assign txClockOutA          = clkOutV[0];
	assign txClockOutOeA        = clkOeV[0];
	assign txClockOutB          = clkOutV[1];
	assign txClockOutOeB        = clkOeV[1];
	assign txMultipurposeOutA   = mpOutV[0];
	assign txMultipurposeOutOeA = mpOeV[0];
	assign txMultipurposeOutB   = mpOutV[1];
	assign txMultipurposeOutOeB = mpOeV[1];
	assign lineOutPosA          = posV[0];
	assign lineOutPosOeA        = lineOeV[0];
	assign lineOutNegA          = negV[0];
	assign lineOutNegOeA        = lineOeV[0];
	assign lineOutPosB          = posV[1];
	assign lineOutPosOeB        = lineOeV[1];
	assign lineOutNegB          = negV[1];
	assign lineOutNegOeB        = lineOeV[1];

endmodule // bits_transmitter_pin_control

// ### verification/bits_transmitter_pin_control_props.sv
// port assertions for the transmitter pin control block
`timescale 1ns/1ps
module bits_transmitter_pin_control_props (
	input wire logic                         clk,
	input wire logic                         rst_b,
	input wire logic                         linkClk,
	input wire logic                         cyc_i,
	input wire logic                         stb_i,
	input wire logic                         we_i,
	input wire logic [tx_pin_pkg::ADR_W-1:0] adr_i,
	input wire logic [tx_pin_pkg::DAT_W-1:0] dat_o,
	input wire logic                         ack_o,
	input wire logic                         lineHizInA,
	input wire logic                         lineHizInB,
	input wire logic                         txClockOutOeA,
	input wire logic                         txClockOutOeB,
	input wire logic                         txMultipurposeOutOeA,
	input wire logic                         txMultipurposeOutOeB,
	input wire logic                         lineOutPosA,
	input wire logic                         lineOutNegA,
	input wire logic                         lineOutPosOeA,
	input wire logic                         lineOutNegOeA,
	input wire logic                         lineOutPosB,
	input wire logic                         lineOutNegB,
	input wire logic                         lineOutPosOeB,
	input wire logic                         lineOutNegOeB
);
	ack_pulse_a: assert property (@(posedge clk) disable iff (!rst_b)
		ack_o |=> !ack_o) else $error("ack longer than one cycle");
	ack_cause_a: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(ack_o) |-> $past(cyc_i && stb_i)) else $error("ack without request");
	unmapped_read_a: assert property (@(posedge clk) disable iff (!rst_b)
		ack_o && !we_i && !(adr_i inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10})
		|-> dat_o == '0) else $error("unmapped read not zero");
	hiz_line_a: assert property (@(posedge linkClk) disable iff (!rst_b)
		lineHizInA [*5] |-> !lineOutPosOeA) else $error("line a driven under hiz");
	hiz_other_a: assert property (@(posedge linkClk) disable iff (!rst_b)
		lineHizInB [*5] |-> !lineOutPosOeB) else $error("line b driven under hiz");
	oe_pair_a: assert property (@(posedge linkClk) disable iff (!rst_b)
		lineOutPosOeA == lineOutNegOeA && lineOutPosOeB == lineOutNegOeB)
		else $error("line enables differ");
	idle_low_a: assert property (@(posedge linkClk) disable iff (!rst_b)
		!lineOutPosOeA [*2] |-> !lineOutPosA && !lineOutNegA)
		else $error("line a active while undriven");
	ami_line_a: assert property (@(posedge linkClk) disable iff (!rst_b)
		!(lineOutPosA && lineOutNegA) && !(lineOutPosB && lineOutNegB))
		else $error("both line halves high");
	link_reset_a: assert property (@(posedge linkClk)
		!rst_b [*4] |-> !txClockOutOeA && !txClockOutOeB && !txMultipurposeOutOeA
		&& !txMultipurposeOutOeB && !lineOutPosOeA && !lineOutPosOeB)
		else $error("pin driven in reset");
endmodule // bits_transmitter_pin_control_props

bind bits_transmitter_pin_control bits_transmitter_pin_control_props i_props (
	.clk, .rst_b, .linkClk, .cyc_i, .stb_i, .we_i, .adr_i, .dat_o, .ack_o, .lineHizInA,
	.lineHizInB, .txClockOutOeA, .txClockOutOeB, .txMultipurposeOutOeA, .txMultipurposeOutOeB,
	.lineOutPosA, .lineOutNegA, .lineOutPosOeA, .lineOutNegOeA, .lineOutPosB, .lineOutNegB,
	.lineOutPosOeB, .lineOutNegOeB);

// ### verification/tx_far_end.sv
// far-end logic: output clocks, pin clock and serial data
`timescale 1ns/1ps
module tx_far_end (
	input  wire logic                          linkClk,
	input  wire logic                          pinMode,
	input  wire logic                          dataLevel,
	output logic      [tx_pin_pkg::OC_W-1:0]   outputClock,
	output logic                               txMultipurposeInA,
	output logic                               txMultipurposeInB,
	output logic                               txSerialDataInA,
	output logic                               txSerialDataInB
);
	int cnt = 0;

	always_ff @(posedge linkClk)
		cnt <= cnt + 1;
	// clock i holds each level i+2 cycles, never faster than linkClk/4
	for (genvar i = 0; i < tx_pin_pkg::OC_W; i++)
	begin : g_oc
		assign outputClock[i] = 1'(cnt / (i + 2));
	end
	// pin clock only when asked, otherwise the pull-down level
	assign txMultipurposeInA = pinMode & 1'(cnt / 3);
	assign txMultipurposeInB = txMultipurposeInA;
	assign txSerialDataInA = dataLevel;
	assign txSerialDataInB = dataLevel;
endmodule // tx_far_end

// ### verification/bits_transmitter_pin_control_tb_top.sv
// self-checking bench for the transmitter pin control block
`timescale 1ns/1ps
module bits_transmitter_pin_control_tb_top;
	logic        clk = 0, linkClk = 0, rst_b = 0, cyc_i = 0, stb_i = 0, we_i = 0, ack_o;
	logic [7:0]  adr_i = '0;
	logic [3:0]  sel_i = '0, mon;
	logic [31:0] dat_i = '0, dat_o, rd;
	logic [8:0]  outputClock;
	logic        pinMode = 0, dataLevel = 1, lineHizInA = 0, lineHizInB = 0;
	logic        txMultipurposeInA, txMultipurposeInB, txSerialDataInA, txSerialDataInB;
	logic        txClockOutA, txClockOutOeA, txClockOutB, txClockOutOeB, txMultipurposeOutA;
	logic        txMultipurposeOutOeA, txMultipurposeOutB, txMultipurposeOutOeB, lineOutPosA;
	logic        lineOutPosOeA, lineOutNegA, lineOutNegOeA, lineOutPosB, lineOutPosOeB;
	logic        lineOutNegB, lineOutNegOeB;
	int          nFail = 0, checksDone = 0, cnt[5];
	logic [15:0] oe[3] = '{16'h0001, 16'h0004, 16'h0500};
	logic [5:0]  hz[6] = '{6'h05, 6'h15, 6'h25, 6'h04, 6'h07, 6'h0D};

	always #2.5 clk = ~clk;
	always #15 linkClk = ~linkClk;
	assign mon = {txMultipurposeOutA, lineOutPosA, txClockOutB, txClockOutA};

	tx_far_end i_far (.linkClk, .pinMode, .dataLevel, .outputClock, .txMultipurposeInA,
		.txMultipurposeInB, .txSerialDataInA, .txSerialDataInB);
	bits_transmitter_pin_control i_dut (.clk, .rst_b, .linkClk, .cyc_i, .stb_i, .we_i,
		.adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .outputClock, .txMultipurposeInA,
		.txMultipurposeInB, .txSerialDataInA, .txSerialDataInB, .lineHizInA, .lineHizInB,
		.txClockOutA, .txClockOutOeA, .txClockOutB, .txClockOutOeB, .txMultipurposeOutA,
		.txMultipurposeOutOeA, .txMultipurposeOutB, .txMultipurposeOutOeB, .lineOutPosA,
		.lineOutPosOeA, .lineOutNegA, .lineOutNegOeA, .lineOutPosB, .lineOutPosOeB,
		.lineOutNegB, .lineOutNegOeB);

	task automatic end_of_test();
		if (nFail == 0 && checksDone > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, exp);
		checksDone++;
		if (seen !== exp)
		begin
			nFail++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		cyc_i <= 1;
		stb_i <= 1;
		we_i <= w;
		adr_i <= a;
		sel_i <= s;
		dat_i <= d;
		// only the watchdog ends a wait
		do
			@(posedge clk);
		while (ack_o !== 1'b1);
		q = dat_o;
		cyc_i <= 0;
		stb_i <= 0;
		we_i <= 0;
	endtask

	task automatic lw(input int n);
		repeat (n) @(posedge linkClk);
	endtask

	// rising edges over n link cycles; last slot: line pulses after a low clock
	task automatic win(input int n);
		logic [3:0] prev;
		cnt = '{default: 0};
		prev = mon;
		repeat (n)
		begin
			@(posedge linkClk);
			for (int k = 0; k < 4; k++)
				if (mon[k] && !prev[k])
					cnt[k]++;
			if (mon[2] && !prev[2] && !prev[0])
				cnt[4]++;
			prev = mon;
		end
	endtask

	// edges in 480 link cycles for each source code
	function automatic int edges(input int code);
		if (code == 0)
			return 80;
		if (code == 9)
			return 24;
		if (code > 7)
			return 0;
		return 240 / (code + 1);
	endfunction

	initial
	begin
		repeat (95000) @(posedge clk);
		nFail++;
		end_of_test();
	end

	initial
	begin
		// link reset needs several link edges
		repeat (5) @(posedge linkClk);
		@(posedge clk);
		rst_b <= 1;
		for (int a = 0; a < 16; a += 4)
		begin
			bus(0, 8'(a), 4'hF, '0, rd);
			check("reset value", rd, '0);
		end
		bus(1, 8'h14, 4'hF, 32'hFFFF_FFFF, rd);
		bus(0, 8'h14, 4'hF, '0, rd);
		check("unmapped", rd, '0);
		bus(1, 8'h04, 4'h1, 32'h0000_4545, rd);
		bus(1, 8'h04, 4'h2, 32'h0000_0303, rd);
		bus(0, 8'h04, 4'hF, '0, rd);
		check("lane write", rd, 32'h0000_0345);
		foreach (oe[i])
		begin
			bus(1, 8'h04, 4'hF, 32'(oe[i]), rd);
			lw(8);
			check("clock oe", {txClockOutOeB, txClockOutOeA}, {oe[i][8], oe[i][0]});
			check("sync oe", {txMultipurposeOutOeB, txMultipurposeOutOeA},
				{oe[i][10], oe[i][2]});
		end
		pinMode <= 1;
		bus(1, 8'h04, 4'hF, 32'h0000_0101, rd);
		for (int c = 0; c < 10; c++)
		begin
			bus(1, 8'h00, 4'hF, 32'h10 | 32'(c), rd);
			lw(10);
			win(480);
			check("clock a", 32'(cnt[0] >= edges(c) - 1 && cnt[0] <= edges(c) + 1), 32'h1);
			check("clock b", 32'(cnt[1] >= 119 && cnt[1] <= 121), 32'h1);
		end
		bus(1, 8'h00, 4'hF, 32'h11, rd);
		bus(1, 8'h0C, 4'hF, 32'h5, rd);
		dataLevel <= 0;
		for (int m = 0; m < 4; m++)
		begin
			bus(1, 8'h08, 4'hF, 32'(m), rd);
			lw(10);
			win(480);
			check("line ones", 32'(cnt[2] >= 50), 32'(m >= 2));
			check("rise edge", cnt[4], '0);
		end
		dataLevel <= 1;
		bus(1, 8'h04, 4'hF, 32'h0000_0103, rd);
		bus(1, 8'h08, 4'hF, '0, rd);
		lw(10);
		win(480);
		check("line ones", 32'(cnt[2] >= 50), 32'h1);
		check("line oe", lineOutPosOeA, 1'b1);
		check("fall edge", cnt[4], cnt[2]);
		for (int s = 0; s < 2; s++)
		begin
			bus(1, 8'h04, 4'hF, 32'h0105 | 32'(s << 3), rd);
			lw(10);
			win(1600);
			check("sync pulses", 32'(cnt[3] >= 2), 32'(s == 0));
		end
		// frame sync taken from the toggling multipurpose input
		bus(1, 8'h04, 4'hF, 32'h0000_0115, rd);
		lw(10);
		win(480);
		check("resync pulses", 32'(cnt[3] >= 20), 32'h1);
		foreach (hz[i])
		begin
			bus(1, 8'h0C, 4'hF, 32'(hz[i][3:0]), rd);
			lineHizInA <= hz[i][4];
			lineHizInB <= hz[i][5];
			lw(8);
			check("line a oe", lineOutPosOeA, hz[i][0] & ~hz[i][1] & ~hz[i][4]);
			check("line b oe", lineOutPosOeB, hz[i][2] & ~hz[i][3] & ~hz[i][5]);
		end
		end_of_test();
	end
endmodule // bits_transmitter_pin_control_tb_top
